// >>> rtl/ppsdl_top.sv
// pulse-per-second discipline loop for a rubidium standard
// assumes ref_pps and osc_warm are asynchronous pins; one core clock
`timescale 1ns/1ns

// Function
// - rising reference edge is the timing event
// - lock after 256 good pulses within 2048 ns
// - ignore pulses over 1024 ns from last good
// - 256 bad pulses abort and requalify
// - second-order loop, time constant 65536 s
// - output pulse only while disciplined
// - 400 ns timer plus 100/0.5 ns stages
// - led blue init, yellow warm, green locked
module ppsdl_top
    import ppsdl_pkg::*;
#(
    parameter int unsigned SEC_CYC   = CLK_HZ,
    parameter int unsigned RUN_LEN   = RUN_LEN_DEF,
    parameter int unsigned PULSE_CYC = PULSE_CYC_DEF
)(
    input  wire logic         core_clk,
    input  wire logic         reset,
    input  wire logic         ref_pps,
    input  wire logic         osc_warm,
    output logic [31:0]       freq_adj,
    output logic              pps_out,
    output logic [FINE_W-1:0] fine_delay,
    output logic              locked,
    output logic              led_blue,
    output logic              led_yellow,
    output logic              led_green
);

    localparam logic [CNT_W-1:0] SEC_V   = CNT_W'(SEC_CYC);
    localparam logic [RUN_W-1:0] RUN_TOP = RUN_W'(RUN_LEN - 1);

    function automatic logic signed [CNT_W:0] phase_of(
        input logic [CNT_W-1:0] c
    );
        if (c < (SEC_V >> 1))
            phase_of = $signed({1'b0, c});
        else
            phase_of = $signed({1'b0, c}) - $signed({1'b0, SEC_V});
    endfunction

    function automatic logic [CNT_W:0] mag(
        input logic signed [CNT_W:0] v
    );
        mag = v[CNT_W] ? $unsigned(-v) : $unsigned(v);
    endfunction

    ppsdl_state_t       state_q, state_d;
    logic [2:0]         ref_sync_q;
    logic [1:0]         warm_sync_q;
    logic [CNT_W-1:0]   sec_q,   sec_d;
    logic               first_q, first_d;
    logic [RUN_W-1:0]   good_q,  good_d;
    logic [RUN_W-1:0]   bad_q,   bad_d;
    logic signed [CNT_W:0] last_q, last_d;
    logic signed [31:0] integ_q, integ_d;
    logic signed [31:0] freq_q,  freq_d;
    logic signed [31:0] phase_q, phase_d;
    logic [2:0]         led_q,   led_d;
    logic               ref_edge;
    logic               good_evt;
    logic               bad_evt;
    logic signed [CNT_W:0] off;
    logic signed [CNT_W:0] diff;
    logic signed [31:0] off32;
    logic signed [31:0] place_s;
    logic [PLACE_W-1:0] place;

    // only the second and third stages feed the edge detector
    assign ref_edge = ref_sync_q[1] && !ref_sync_q[2];
    assign off      = phase_of(sec_q);
    assign diff     = off - last_q;
    assign off32    = 32'(off);

    always_comb
    begin
        state_d  = state_q;
        sec_d    = (sec_q == SEC_V - 1'b1) ? '0 : sec_q + 1'b1;
        first_d  = first_q;
        good_d   = good_q;
        bad_d    = bad_q;
        last_d   = last_q;
        integ_d  = integ_q;
        freq_d   = freq_q;
        phase_d  = phase_q;
        good_evt = 1'b0;
        bad_evt  = 1'b0;
        unique case (state_q)
            ST_INIT:
            begin
                if (warm_sync_q[1])
                    state_d = ST_QUAL;
            end
            ST_QUAL:
            begin
                if (ref_edge && !first_q)
                begin
                    // first pulse defines the local epoch
                    first_d = 1'b1;
                    sec_d   = CNT_W'(1);
                    good_d  = RUN_W'(1);
                    bad_d   = '0;
                    last_d  = '0;
                end
                else if (ref_edge)
                begin
                    good_evt = mag(off) <= (CNT_W+1)'(GOOD_WIN_CYC);
                    bad_evt  = !good_evt;
                end
            end
            ST_LOCK:
            begin
                if (ref_edge)
                begin
                    good_evt = mag(diff) <= (CNT_W+1)'(OUTLIER_CYC);
                    bad_evt  = !good_evt;
                end
            end
            default:
            begin
                state_d = ST_INIT;
            end
        endcase
        if (good_evt)
        begin
            good_d = good_q + 1'b1;
            bad_d  = '0;
            last_d = off;
            if (state_q == ST_LOCK)
            begin
                // proportional plus integral, scaled by the time constant
                integ_d = integ_q + off32;
                freq_d  = off32 + (integ_d >>> TC_SHIFT);
                phase_d = phase_q + ((off32 * $signed(32'(HN_PER_CYC)))
                          >>> PH_SHIFT);
            end
            else if (good_q == RUN_TOP)
            begin
                state_d = ST_LOCK;
                good_d  = '0;
                integ_d = '0;
            end
        end
        if (bad_evt)
        begin
            good_d = '0;
            bad_d  = bad_q + 1'b1;
            if (bad_q == RUN_TOP)
            begin
                // restart from scratch; freq_q holds the last steer value
                state_d = ST_QUAL;
                first_d = 1'b0;
                bad_d   = '0;
            end
        end
        unique case (state_d)
            ST_INIT: led_d = 3'b100;
            ST_QUAL: led_d = 3'b010;
            ST_LOCK: led_d = 3'b001;
            default: led_d = 3'b100;
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            state_q     <= ST_INIT;
            ref_sync_q  <= '0;
            warm_sync_q <= '0;
            sec_q       <= '0;
            first_q     <= 1'b0;
            good_q      <= '0;
            bad_q       <= '0;
            last_q      <= '0;
            integ_q     <= '0;
            freq_q      <= '0;
            phase_q     <= '0;
            led_q       <= 3'b100;
        end
        else
        begin
            state_q     <= state_d;
            ref_sync_q  <= {ref_sync_q[1:0], ref_pps};
            warm_sync_q <= {warm_sync_q[0], osc_warm};
            sec_q       <= sec_d;
            first_q     <= first_d;
            good_q      <= good_d;
            bad_q       <= bad_d;
            last_q      <= last_d;
            integ_q     <= integ_d;
            freq_q      <= freq_d;
            phase_q     <= phase_d;
            led_q       <= led_d;
        end
    end

    // clamp keeps the output inside the placement range
    always_comb
    begin
        place_s = 32'(PLACE_BASE) + phase_q;
        if (place_s < 0)
            place = '0;
        else if (place_s > 32'(PLACE_MAX))
            place = PLACE_MAX;
        else
            place = place_s[PLACE_W-1:0];
    end

    assign locked     = (state_q == ST_LOCK);
    assign freq_adj   = freq_q;
    assign led_blue   = led_q[2];
    assign led_yellow = led_q[1];
    assign led_green  = led_q[0];

    ppsdl_place #(
        .PULSE_CYC (PULSE_CYC)
    ) u_place (
        .core_clk   (core_clk),
        .reset      (reset),
        .enable     (locked),
        .epoch      (sec_q == '0),
        .place      (place),
        .pps_out    (pps_out),
        .fine_delay (fine_delay)
    );

    property p_edge_seen;
        @(posedge core_clk) disable iff (reset)
        ref_edge |=> ref_sync_q[2] && $past(!ref_sync_q[2]);
    endproperty
    a_edge_seen: assert property (p_edge_seen)
        else $error("edge not taken on a rising reference");

    property p_lock_run;
        @(posedge core_clk) disable iff (reset)
        $rose(locked) |-> $past(good_q) == RUN_TOP && $past(good_evt);
    endproperty
    a_lock_run: assert property (p_lock_run)
        else $error("lock without a full run of good pulses");

    property p_qual_window;
        @(posedge core_clk) disable iff (reset)
        state_q == ST_QUAL && ref_edge && first_q
            && mag(off) > (CNT_W+1)'(GOOD_WIN_CYC) |-> bad_evt;
    endproperty
    a_qual_window: assert property (p_qual_window)
        else $error("pulse outside window counted as good");

    property p_outlier_ignored;
        @(posedge core_clk) disable iff (reset)
        locked && bad_evt |=> $stable(integ_q) && $stable(phase_q);
    endproperty
    a_outlier_ignored: assert property (p_outlier_ignored)
        else $error("outlier pulse moved the loop");

    property p_abort;
        @(posedge core_clk) disable iff (reset)
        locked && bad_evt && bad_q == RUN_TOP
            |=> state_q == ST_QUAL && !first_q && bad_q == '0;
    endproperty
    a_abort: assert property (p_abort)
        else $error("long bad run did not restart qualification");

    property p_integ;
        @(posedge core_clk) disable iff (reset)
        locked && good_evt |=> integ_q == $past(integ_q) + $past(off32);
    endproperty
    a_integ: assert property (p_integ)
        else $error("integrator not advanced by phase error");

    property p_no_out_unlocked;
        @(posedge core_clk) disable iff (reset)
        !locked |=> !pps_out;
    endproperty
    a_no_out_unlocked: assert property (p_no_out_unlocked)
        else $error("pulse output while not disciplined");

    property p_led;
        @(posedge core_clk) disable iff (reset)
        (locked == led_green) && ((state_q == ST_INIT) == led_blue)
            && ((state_q == ST_QUAL) == led_yellow);
    endproperty
    a_led: assert property (p_led)
        else $error("status colour does not match state");

    property p_bad_clears_good;
        @(posedge core_clk) disable iff (reset)
        bad_evt |=> good_q == '0;
    endproperty
    a_bad_clears_good: assert property (p_bad_clears_good)
        else $error("bad pulse left good run standing");

    property p_good_clears_bad;
        @(posedge core_clk) disable iff (reset)
        good_evt |=> bad_q == '0;
    endproperty
    a_good_clears_bad: assert property (p_good_clears_bad)
        else $error("good pulse left bad run standing");

endmodule

// >>> include/ppsdl_pkg.sv
// shared constants and types for the pulse-per-second discipline loop
// assumes a single 50 MHz core clock and a rising-edge reference pulse
package ppsdl_pkg;

    // clock
    localparam int unsigned CLK_HZ        = 50_000_000;
    localparam int unsigned CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
    localparam int unsigned CNT_W         = 26;

    // qualification windows, rounded down to whole cycles
    localparam int unsigned GOOD_WIN_NS   = 2048;
    localparam int unsigned GOOD_WIN_CYC  = GOOD_WIN_NS / CLK_PERIOD_NS;
    localparam int unsigned OUTLIER_NS    = 1024;
    localparam int unsigned OUTLIER_CYC   = OUTLIER_NS / CLK_PERIOD_NS;

    // run lengths for lock and abort
    localparam int unsigned RUN_LEN_DEF   = 256;
    localparam int unsigned RUN_W         = 9;

    // loop time constant
    localparam int unsigned TC_SEC        = 65536;
    localparam int unsigned TC_SHIFT      = $clog2(TC_SEC);
    localparam int unsigned PH_SHIFT      = 3;

    // output placement, in half-nanosecond units
    localparam int unsigned COARSE_NS     = 400;
    localparam int unsigned COARSE_CYC    = COARSE_NS / CLK_PERIOD_NS;
    localparam int unsigned MID_NS        = 100;
    localparam int unsigned MID_CYC       = MID_NS / CLK_PERIOD_NS;
    localparam int unsigned HN_PER_NS     = 2;
    localparam int unsigned HN_PER_COARSE = COARSE_NS * HN_PER_NS;
    localparam int unsigned HN_PER_MID    = MID_NS * HN_PER_NS;
    localparam int unsigned HN_PER_CYC    = CLK_PERIOD_NS * HN_PER_NS;
    localparam int unsigned FINE_W        = 8;
    localparam int unsigned PLACE_W       = 20;
    localparam int unsigned WAIT_W        = 16;
    localparam logic [PLACE_W-1:0] PLACE_BASE = 20'h01000;
    localparam logic [PLACE_W-1:0] PLACE_MAX  = 20'hfffff;

    // output pulse width
    localparam int unsigned PULSE_NS      = 10_000;
    localparam int unsigned PULSE_CYC_DEF = PULSE_NS / CLK_PERIOD_NS;

    typedef enum logic [2:0] {
        ST_INIT = 3'b001,
        ST_QUAL = 3'b010,
        ST_LOCK = 3'b100
    } ppsdl_state_t;

endpackage

// >>> rtl/ppsdl_place.sv
// output pulse placement: coarse timer, 100 ns stage, 0.5 ns delay code
// assumes epoch pulses one second apart from the loop's second counter
`timescale 1ns/1ns
module ppsdl_place
    import ppsdl_pkg::*;
#(
    parameter int unsigned PULSE_CYC = PULSE_CYC_DEF
)(
    input  wire logic               core_clk,
    input  wire logic               reset,
    input  wire logic               enable,
    input  wire logic               epoch,
    input  wire logic [PLACE_W-1:0] place,
    output logic                    pps_out,
    output logic [FINE_W-1:0]       fine_delay
);

    logic               run_q,   run_d;
    logic [WAIT_W-1:0]  wait_q,  wait_d;
    logic [WAIT_W-1:0]  width_q, width_d;
    logic               pps_q,   pps_d;
    logic [FINE_W-1:0]  fine_q,  fine_d;
    logic [PLACE_W-1:0] coarse;
    logic [PLACE_W-1:0] mid;

    always_comb
    begin
        coarse  = PLACE_W'(place / PLACE_W'(HN_PER_COARSE));
        mid     = PLACE_W'((place % PLACE_W'(HN_PER_COARSE))
                  / PLACE_W'(HN_PER_MID));
        run_d   = run_q;
        wait_d  = wait_q;
        width_d = (width_q != '0) ? width_q - 1'b1 : width_q;
        fine_d  = fine_q;
        if (!enable)
        begin
            // dropping lock kills a pulse in flight
            run_d   = 1'b0;
            width_d = '0;
        end
        else if (epoch)
        begin
            run_d  = 1'b1;
            wait_d = WAIT_W'(coarse * COARSE_CYC + mid * MID_CYC);
            fine_d = FINE_W'(place % PLACE_W'(HN_PER_MID));
        end
        else if (run_q)
        begin
            if (wait_q == '0)
            begin
                run_d   = 1'b0;
                width_d = WAIT_W'(PULSE_CYC);
            end
            else
            begin
                wait_d = wait_q - 1'b1;
            end
        end
        pps_d = enable && (width_d != '0);
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            run_q   <= 1'b0;
            wait_q  <= '0;
            width_q <= '0;
            pps_q   <= 1'b0;
            fine_q  <= '0;
        end
        else
        begin
            run_q   <= run_d;
            wait_q  <= wait_d;
            width_q <= width_d;
            pps_q   <= pps_d;
            fine_q  <= fine_d;
        end
    end

    assign pps_out    = pps_q;
    assign fine_delay = fine_q;

    property p_pulse_after_wait;
        @(posedge core_clk) disable iff (reset)
        $rose(pps_q) |-> $past(run_q) && $past(wait_q) == '0;
    endproperty
    a_pulse_after_wait: assert property (p_pulse_after_wait)
        else $error("output pulse not at end of coarse wait");

    property p_fine_range;
        @(posedge core_clk) disable iff (reset)
        fine_q < FINE_W'(HN_PER_MID);
    endproperty
    a_fine_range: assert property (p_fine_range)
        else $error("fine delay code beyond one 100 ns step");

endmodule

// >>> bench/ppsdl_ref_model.sv
// reference receiver model: one rising pulse per model second
// assumes bench sets offset between pulses; latched at second wrap
`timescale 1ns/1ns
module ppsdl_ref_model
#(
    parameter int unsigned SEC_CYC = 2000
)(
    input  wire logic        core_clk,
    input  wire logic        reset,
    input  wire logic        enable,
    input  wire logic [15:0] offset,
    output logic             ref_pps
);
    logic [15:0] cnt_q;
    logic [15:0] off_q;
    logic [2:0]  hi_q;

    // offset taken at wrap so a late change never fires twice a second
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            cnt_q <= 16'h0000;
            off_q <= 16'h0000;
            hi_q  <= 3'h0;
        end
        else
        begin
            cnt_q <= (cnt_q == 16'(SEC_CYC - 1)) ? 16'h0000 : cnt_q + 16'h0001;
            if (cnt_q == 16'(SEC_CYC - 1))
                off_q <= offset;
            if (enable && cnt_q == off_q)
                hi_q <= 3'h4;
            else if (hi_q != 3'h0)
                hi_q <= hi_q - 3'h1;
        end
    end

    assign ref_pps = (hi_q != 3'h0);
endmodule

// >>> bench/testbench.sv
// self-checking bench for the discipline loop, shortened second and runs
// assumes ppsdl_pkg compiled first and the reference model beside it
`timescale 1ns/1ns
module testbench;
    import ppsdl_pkg::*;

    localparam int unsigned SEC   = 2000;
    localparam int unsigned RUN   = 4;
    localparam int unsigned PW    = 50;
    localparam int unsigned LIMIT = 70000;

    logic              core_clk;
    logic              reset;
    logic              ref_pps;
    logic              osc_warm;
    logic              enable;
    logic [15:0]       offset;
    logic [31:0]       freq_adj;
    logic              pps_out;
    logic [FINE_W-1:0] fine_delay;
    logic              locked;
    logic              led_blue;
    logic              led_yellow;
    logic              led_green;
    int                error_cnt;
    int                n_compared;
    int                cyc;

    ppsdl_top #(.SEC_CYC(SEC), .RUN_LEN(RUN), .PULSE_CYC(PW)) dut (
        .core_clk   (core_clk),
        .reset      (reset),
        .ref_pps    (ref_pps),
        .osc_warm   (osc_warm),
        .freq_adj   (freq_adj),
        .pps_out    (pps_out),
        .fine_delay (fine_delay),
        .locked     (locked),
        .led_blue   (led_blue),
        .led_yellow (led_yellow),
        .led_green  (led_green)
    );

    ppsdl_ref_model #(.SEC_CYC(SEC)) ref_src (
        .core_clk (core_clk),
        .reset    (reset),
        .enable   (enable),
        .offset   (offset),
        .ref_pps  (ref_pps)
    );

    task automatic print_verdict();
        if (error_cnt == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("unexpected at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask

    function automatic logic [31:0] leds();
        return {29'h0, led_blue, led_yellow, led_green};
    endfunction

    // one reference pulse; returns once detection has settled
    task automatic send(input logic [15:0] off);
        int n;
        n = 0;
        @(posedge core_clk) offset <= off;
        while (ref_pps !== 1'b1 && n < 3 * SEC)
        begin
            @(negedge core_clk);
            n++;
        end
        repeat (6) @(negedge core_clk);
    endtask

    // send returns three cycles after the epoch load and the pulse
    // follows one cycle after the wait ends, so two cycles drop out
    task automatic check_out(input logic [FINE_W-1:0] exp_fine,
                             input int                exp_wait);
        int n;
        int w;
        n = 0;
        w = 0;
        while (pps_out !== 1'b1 && n < 300)
        begin
            @(negedge core_clk);
            n++;
        end
        chk(32'(n), 32'(exp_wait - 2));
        chk(32'(fine_delay), 32'(exp_fine));
        while (pps_out === 1'b1 && w < 1000)
        begin
            @(negedge core_clk);
            w++;
        end
        chk(32'(w), PW);
    endtask

    task automatic t_init();
        chk(leds(), 32'h4);
        chk(32'(locked), 32'h0);
        chk(freq_adj, 32'h0);
        @(posedge core_clk) enable <= 1'b1;
        send(16'h0000);
        send(16'h0000);
        chk(leds(), 32'h4);
        chk(32'(pps_out), 32'h0);
    endtask

    task automatic t_warm();
        @(posedge core_clk) osc_warm <= 1'b1;
        repeat (8) @(negedge core_clk);
        chk(leds(), 32'h2);
    endtask

    task automatic t_qualify();
        repeat (3) send(16'h0000);
        send(16'h0067);
        chk(32'(locked), 32'h0);
        send(16'h0000);
        send(16'h0066);
        send(16'h0000);
        chk(32'(locked), 32'h0);
        send(16'h0000);
        chk(32'(locked), 32'h1);
        chk(leds(), 32'h1);
    endtask

    task automatic t_output();
        send(16'h0000);
        check_out(8'h60, 5 * COARSE_CYC);
        chk(freq_adj, 32'h0);
    endtask

    task automatic t_loop();
        send(16'h000a);
        chk(freq_adj, 32'h0000000a);
        send(16'h0000);
        chk(freq_adj, 32'h0);
        check_out(8'h92, 5 * COARSE_CYC);
        send(16'h0033);
        chk(freq_adj, 32'h00000033);
        send(16'h0000);
        chk(freq_adj, 32'h0);
        check_out(8'h01, 5 * COARSE_CYC + 2 * MID_CYC);
    endtask

    task automatic t_outlier();
        send(16'h0034);
        chk(freq_adj, 32'h0);
        chk(32'(locked), 32'h1);
    endtask

    task automatic t_abort();
        logic seen;
        seen = 1'b0;
        repeat (2) send(16'h012c);
        send(16'h0000);
        repeat (3) send(16'h012c);
        chk(32'(locked), 32'h1);
        send(16'h012c);
        chk(32'(locked), 32'h0);
        chk(leds(), 32'h2);
        // this second's pulse becomes the new first pulse
        repeat (SEC)
        begin
            @(negedge core_clk);
            if (pps_out !== 1'b0)
                seen = 1'b1;
        end
        chk(32'(seen), 32'h0);
        repeat (2) send(16'h012c);
        chk(32'(locked), 32'h0);
        send(16'h012c);
        chk(32'(locked), 32'h1);
    endtask

    initial
    begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    always @(posedge core_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == LIMIT)
        begin
            error_cnt++;
            print_verdict();
        end
    end

    initial
    begin
        reset      = 1'b1;
        osc_warm   = 1'b0;
        enable     = 1'b0;
        offset     = 16'h0000;
        error_cnt  = 0;
        n_compared = 0;
        cyc        = 0;
        repeat (12) @(posedge core_clk);
        reset <= 1'b0;
        repeat (2) @(negedge core_clk);
        t_init();
        t_warm();
        t_qualify();
        t_output();
        t_loop();
        t_outlier();
        t_abort();
        print_verdict();
    end
endmodule
